// ===== shared/qpfep_pkg.sv
// Shared constants and types for the quad-phase fetch/execute sequencer.
package qpfep_pkg;

    // ------------------------------------------------------------------
    // Clocking
    // ------------------------------------------------------------------
    localparam int SYS_CLK_HZ = 40_000_000;
    localparam int PHASES_PER_CYCLE = 4;

    // Phase order is Gray coded so that only one bit moves per step.
    typedef enum logic [1:0] {
        PH_ONE = 2'h0,
        PH_TWO = 2'h1,
        PH_THREE = 2'h3,
        PH_FOUR = 2'h2
    } qpfep_phase_e;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int PC_W_DEFAULT = 21;
    localparam int WORD_W = 16;
    localparam int DM_ADDR_W = 12;
    localparam int DM_DATA_W = 8;
    localparam logic [20:0] RESET_ADDR = 21'h000000;
    localparam logic [15:0] NOP_WORD = 16'h0000;

    // ------------------------------------------------------------------
    // Instruction fields and encodings
    // ------------------------------------------------------------------
    localparam int TAG_LSB = 12;
    localparam int OP8_LSB = 8;
    localparam int OP7_LSB = 9;
    localparam int OP5_LSB = 11;
    localparam int REL_OFS_W = 11;
    localparam int LIT_W = 12;
    localparam logic [3:0] SECOND_TAG = 4'hF;
    localparam logic [3:0] MOVE_TAG = 4'hC;
    localparam logic [7:0] JUMP_OP = 8'hEF;
    localparam logic [6:0] CALL_OP = 7'h76;
    localparam logic [7:0] PTR_OP = 8'hEE;
    localparam logic [6:0] SKIP_OP = 7'h33;
    localparam logic [4:0] REL_OP = 5'h1A;

endpackage : qpfep_pkg

// ===== rtl/qpfep_pipeline.sv
// Quad-phase instruction sequencer with a two-stage fetch/execute pipe.
`timescale 1ns/1ps
module qpfep_pipeline
    import qpfep_pkg::*;
#(
    parameter int PC_W = PC_W_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic resetn,
    output logic phase_one_clock,
    output logic phase_two_clock,
    output logic phase_three_clock,
    output logic phase_four_clock,
    output logic [PC_W-1:0] pm_addr,
    output logic pm_rd_en,
    input wire logic [WORD_W-1:0] pm_rdata,
    output logic [DM_ADDR_W-1:0] dm_addr,
    output logic dm_rd_en,
    input wire logic [DM_DATA_W-1:0] dm_rdata,
    output logic dm_wr_en,
    output logic [DM_DATA_W-1:0] dm_wdata,
    output logic [WORD_W-1:0] exec_word,
    output logic exec_valid,
    output logic ptr_load,
    output logic [1:0] ptr_sel,
    output logic [DM_ADDR_W-1:0] ptr_value
);

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    if (PC_W < 12 || PC_W > 21) begin : g_bad_pc_w
        $error("PC_W must lie between 12 and 21");
    end

    localparam int WA_W = PC_W - 1;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------------
    // Phase generator
    // ------------------------------------------------------------------
    qpfep_phase_e phase_q;
    qpfep_phase_e phase_d;

    always_comb begin
        case (phase_q)
            PH_ONE: phase_d = PH_TWO;
            PH_TWO: phase_d = PH_THREE;
            PH_THREE: phase_d = PH_FOUR;
            PH_FOUR: phase_d = PH_ONE;
            default: phase_d = PH_ONE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= PH_ONE;
        end else begin
            phase_q <= phase_d;
        end
    end

    assign phase_one_clock = (phase_q == PH_ONE);
    assign phase_two_clock = (phase_q == PH_TWO);
    assign phase_three_clock = (phase_q == PH_THREE);
    assign phase_four_clock = (phase_q == PH_FOUR);

    // ------------------------------------------------------------------
    // Decode of the word in the latch
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] fetched_word_latch_q;
    logic [WORD_W-1:0] first_q;
    logic expect_q;
    logic flush_q;
    logic skip_zero_q;
    logic is_second, operand_ok, lone_second;
    logic is_jump, is_rel, is_move, is_ptr, is_skip, take;

    // second words carry the 1111 tag
    assign is_second = (fetched_word_latch_q[WORD_W-1:TAG_LSB] == SECOND_TAG);
    // the tag only supplies data right after its first word
    assign operand_ok = is_second && expect_q;
    assign lone_second = is_second && !expect_q;
    assign is_jump = (fetched_word_latch_q[WORD_W-1:OP8_LSB] == JUMP_OP)
        || (fetched_word_latch_q[WORD_W-1:OP7_LSB] == CALL_OP);
    assign is_rel = (fetched_word_latch_q[WORD_W-1:OP5_LSB] == REL_OP);
    assign is_move = (fetched_word_latch_q[WORD_W-1:TAG_LSB] == MOVE_TAG);
    assign is_ptr = (fetched_word_latch_q[WORD_W-1:OP8_LSB] == PTR_OP)
        && (fetched_word_latch_q[7:6] == 2'h0);
    assign is_skip = (fetched_word_latch_q[WORD_W-1:OP7_LSB] == SKIP_OP);
    assign take = is_jump || is_rel || (is_skip && skip_zero_q);

    // ------------------------------------------------------------------
    // Program counter and fetch
    // ------------------------------------------------------------------
    logic [WA_W-1:0] pc_q;
    logic [WA_W-1:0] fetch_wa_q;
    logic [WORD_W-1:0] fetch_buf_q;
    logic [WA_W-1:0] jump_target;
    logic [WA_W-1:0] rel_target;

    // embedded word address lands on counter bits 20..1
    assign jump_target =
        WA_W'({pm_rdata[LIT_W-1:0], fetched_word_latch_q[7:0]});
    // word offset added to the word address doubles it in bytes
    assign rel_target = fetch_wa_q
        + {{(WA_W-REL_OFS_W){fetched_word_latch_q[REL_OFS_W-1]}},
        fetched_word_latch_q[REL_OFS_W-1:0]};

    // The counter holds a word address, so the byte address is always even.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_q <= RESET_ADDR[PC_W-1:1];
            fetch_wa_q <= RESET_ADDR[PC_W-1:1];
        end else if (phase_q == PH_ONE) begin
            // fetch cycle opens with the advance
            fetch_wa_q <= pc_q;
            pc_q <= pc_q + WA_W'(1);
        end else if (phase_q == PH_FOUR && is_jump) begin
            pc_q <= jump_target;
        end else if (phase_q == PH_FOUR && is_rel) begin
            pc_q <= rel_target;
        end
    end

    // byte address with the low bit held at zero
    assign pm_addr = {fetch_wa_q, 1'b0};
    // program memory read in phase four
    assign pm_rd_en = (phase_q == PH_FOUR);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_buf_q <= NOP_WORD;
        end else if (phase_q == PH_FOUR) begin
            fetch_buf_q <= pm_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Latch load and flush
    // ------------------------------------------------------------------
    // A word fetched while the counter was redirected is stale, so it is
    // replaced by a no-op rather than held back; this costs one cycle.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            // start with a no-op in the latch
            fetched_word_latch_q <= NOP_WORD;
            flush_q <= 1'b0;
        end else if (phase_q == PH_ONE) begin
            // latch loads at the end of phase one
            fetched_word_latch_q <= flush_q ? NOP_WORD : fetch_buf_q;
            flush_q <= 1'b0;
        end else if (phase_q == PH_FOUR) begin
            // redirect or skip discards the fetched word
            flush_q <= take;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            expect_q <= 1'b0;
            first_q <= NOP_WORD;
        end else if (phase_q == PH_FOUR) begin
            expect_q <= is_move || is_ptr;
            first_q <= fetched_word_latch_q;
        end
    end

    // one instruction per cycle while the next one is fetched
    assign exec_word = fetched_word_latch_q;
    assign exec_valid = (phase_q != PH_ONE)
        && (fetched_word_latch_q != NOP_WORD) && !lone_second;

    // ------------------------------------------------------------------
    // Data memory timing
    // ------------------------------------------------------------------
    logic [DM_DATA_W-1:0] move_data_q;

    // operand read in phase two, destination write in phase four
    assign dm_rd_en = (phase_q == PH_TWO) && (is_move || is_skip);
    assign dm_wr_en = (phase_q == PH_FOUR) && operand_ok
        && (first_q[WORD_W-1:TAG_LSB] == MOVE_TAG);
    assign dm_addr = is_skip ? {4'h0, fetched_word_latch_q[7:0]}
        : fetched_word_latch_q[DM_ADDR_W-1:0];
    assign dm_wdata = move_data_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            move_data_q <= 8'h00;
            skip_zero_q <= 1'b0;
        end else if (phase_q == PH_TWO) begin
            if (is_move) begin
                move_data_q <= dm_rdata;
            end
            skip_zero_q <= is_skip && (dm_rdata == 8'h00);
        end
    end

    // The pointer load is reported one edge after phase four.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_load <= 1'b0;
            ptr_sel <= 2'h0;
            ptr_value <= 12'h000;
        end else begin
            ptr_load <= (phase_q == PH_FOUR) && operand_ok
                && (first_q[WORD_W-1:OP8_LSB] == PTR_OP);
            if (phase_q == PH_FOUR && operand_ok) begin
                ptr_sel <= first_q[5:4];
                ptr_value <= {first_q[3:0], fetched_word_latch_q[7:0]};
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_jump_seen;
        phase_four_clock && is_jump;
    endsequence

    sequence s_flushed_load;
        phase_one_clock && flush_q ##1 (fetched_word_latch_q == NOP_WORD);
    endsequence

    a_phase_order: assert property (
        phase_four_clock |=> phase_one_clock ##1 phase_two_clock
            ##1 phase_three_clock ##1 phase_four_clock)
        else $error("phase order broken");
    a_phase_onehot: assert property (
        $onehot({phase_one_clock, phase_two_clock,
            phase_three_clock, phase_four_clock}))
        else $error("phases overlap");
    a_pc_advance: assert property (
        phase_one_clock |=> pm_addr == {$past(pc_q), 1'b0})
        else $error("fetch address not advanced");
    a_fetch_phase: assert property (
        pm_rd_en |-> phase_four_clock)
        else $error("fetch outside phase four");
    a_latch_load: assert property (
        phase_one_clock && !flush_q
            |=> fetched_word_latch_q == $past(fetch_buf_q))
        else $error("latch not loaded");
    a_dm_timing: assert property (
        (dm_rd_en |-> phase_two_clock) and (dm_wr_en |-> phase_four_clock))
        else $error("data access in wrong phase");
    a_flush_nop: assert property (
        phase_one_clock && flush_q |-> s_flushed_load)
        else $error("flushed word executed");
    a_jump_target: assert property (
        s_jump_seen |=> pc_q == $past(jump_target) && flush_q)
        else $error("jump target not loaded");
    a_even_addr: assert property (
        pm_addr[0] == 1'b0)
        else $error("odd program address");
    a_lone_second: assert property (
        lone_second |-> !exec_valid && !dm_wr_en && !dm_rd_en)
        else $error("lone second word acted");

endmodule : qpfep_pipeline

// ===== dv/qpfep_mem_model.sv
// Behavioural program and data memory facing the sequencer.
`timescale 1ns/1ps
module qpfep_mem_model
    import qpfep_pkg::*;
#(
    parameter int PC_W = PC_W_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic [PC_W-1:0] pm_addr,
    input wire logic pm_rd_en,
    output logic [WORD_W-1:0] pm_rdata,
    input wire logic [DM_ADDR_W-1:0] dm_addr,
    input wire logic dm_rd_en,
    output logic [DM_DATA_W-1:0] dm_rdata,
    input wire logic dm_wr_en,
    input wire logic [DM_DATA_W-1:0] dm_wdata
);
    logic [WORD_W-1:0] pm [0:63];
    logic [DM_DATA_W-1:0] dm [0:4095];
    always @(posedge sys_clk) begin
        if (dm_wr_en) begin
            dm[dm_addr] <= dm_wdata;
        end
    end
    // Outside a read strobe the lines show the inverse word, so a sampling
    // slip never picks up a plausible value.
    assign pm_rdata = pm_rd_en ? pm[pm_addr[6:1]] : ~pm[pm_addr[6:1]];
    assign dm_rdata = dm_rd_en ? dm[dm_addr] : ~dm[dm_addr];
endmodule : qpfep_mem_model

// ===== dv/tb_top.sv
// Self-checking bench for the quad-phase sequencer.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
    mismatches++; $display("MISMATCH t=%0t got %h exp %h", $time, \
    got, exp); end end
module tb_top;
    import qpfep_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic p1, p2, p3, p4, pm_rd_en, dm_rd_en, dm_wr_en, exec_valid, ptr_load;
    logic [20:0] pm_addr;
    logic [15:0] pm_rdata, exec_word;
    logic [11:0] dm_addr, ptr_value;
    logic [7:0] dm_rdata, dm_wdata;
    logic [1:0] ptr_sel;
    int mismatches = 0;
    int n_compared = 0;
    logic [20:0] fetch_q[$];
    logic [4:0] ph_q[$];
    logic [11:0] rd_q[$];
    logic [19:0] wr_q[$];
    logic [13:0] ptr_q[$];
    logic [16:0] lone_q[$];
    qpfep_pipeline DUT (.sys_clk(sys_clk), .resetn(resetn),
        .phase_one_clock(p1), .phase_two_clock(p2),
        .phase_three_clock(p3), .phase_four_clock(p4),
        .pm_addr(pm_addr), .pm_rd_en(pm_rd_en), .pm_rdata(pm_rdata),
        .dm_addr(dm_addr), .dm_rd_en(dm_rd_en), .dm_rdata(dm_rdata),
        .dm_wr_en(dm_wr_en), .dm_wdata(dm_wdata), .exec_word(exec_word),
        .exec_valid(exec_valid), .ptr_load(ptr_load), .ptr_sel(ptr_sel),
        .ptr_value(ptr_value));
    qpfep_mem_model mem (.sys_clk(sys_clk), .pm_addr(pm_addr),
        .pm_rd_en(pm_rd_en), .pm_rdata(pm_rdata), .dm_addr(dm_addr),
        .dm_rd_en(dm_rd_en), .dm_rdata(dm_rdata), .dm_wr_en(dm_wr_en),
        .dm_wdata(dm_wdata));
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    // ------------------------------------------------------------
    // Port recorders
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (resetn) begin
            ph_q.push_back({pm_rd_en, p1, p2, p3, p4});
            if (pm_rd_en) fetch_q.push_back(pm_addr);
            if (dm_rd_en) rd_q.push_back(dm_addr);
            if (dm_wr_en) wr_q.push_back({dm_addr, dm_wdata});
            if (ptr_load) ptr_q.push_back({ptr_sel, ptr_value});
            if (p2 && exec_word[15:12] === 4'hF) begin
                lone_q.push_back({exec_word, exec_valid});
            end
        end
    end
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        repeat (4) @(posedge sys_clk);
        `CHK(p1, 1'b1)
        `CHK(pm_rd_en, 1'b0)
        `CHK(exec_valid, 1'b0)
        resetn <= 1'b1;
    endtask : t_reset
    task automatic t_run();
        int n;
        for (n = 0; n < 400 && fetch_q.size() < 13; n++) @(posedge sys_clk);
        if (n == 400) begin
            mismatches++;
            $display("MISMATCH t=%0t fetch stream stalled", $time);
            report_and_stop();
        end
    endtask : t_run
    task automatic t_phases();
        logic [3:0] nxt;
        // The internal reset copy holds phase one for two more edges.
        for (int i = 0; i < 3; i++) begin
            `CHK(ph_q[i][3:0], 4'h8)
            `CHK(ph_q[i][4], 1'b0)
        end
        for (int i = 2; i + 1 < ph_q.size(); i++) begin
            nxt = {ph_q[i][0], ph_q[i][3:1]};
            `CHK(ph_q[i + 1][3:0], nxt)
            `CHK(ph_q[i][4], ph_q[i][0])
        end
    endtask : t_phases
    task automatic t_fetch();
        logic [20:0] exp_a[13] = '{21'h00, 21'h02, 21'h04, 21'h06, 21'h10,
            21'h12, 21'h14, 21'h18, 21'h1A, 21'h1C, 21'h1E, 21'h20, 21'h22};
        // The jump at 04 and the relative branch at 12 both redirect.
        for (int i = 0; i < 13; i++) begin
            `CHK(fetch_q[i], exp_a[i])
            `CHK(fetch_q[i][0], 1'b0)
        end
    endtask : t_fetch
    task automatic t_data();
        // A second word runs only right after its own first word.
        logic [16:0] exp_l[4] = '{{16'hF456, 1'b1}, {16'hF777, 1'b0},
            {16'hF05C, 1'b1}, {16'hF200, 1'b0}};
        `CHK(rd_q.size(), 2)
        `CHK(rd_q[0], 12'h123)
        `CHK(rd_q[1], 12'h010)
        `CHK(wr_q.size(), 1)
        `CHK(wr_q[0], {12'h456, 8'h3C})
        `CHK(mem.dm[12'h456], 8'h3C)
        `CHK(ptr_q.size(), 1)
        `CHK(ptr_q[0], {2'h2, 12'hA5C})
        `CHK(lone_q.size(), 4)
        foreach (exp_l[i]) `CHK(lone_q[i], exp_l[i])
    endtask : t_data
    initial begin
        for (int i = 0; i < 4096; i++) mem.dm[i] = 8'h00;
        for (int i = 0; i < 64; i++) mem.pm[i] = NOP_WORD;
        mem.dm[12'h123] = 8'h3C;
        {mem.pm[0], mem.pm[1], mem.pm[2], mem.pm[3]} =
            {16'hC123, 16'hF456, 16'hEF08, 16'hF000};
        {mem.pm[8], mem.pm[9]} = {16'hF777, 16'hD002};
        {mem.pm[12], mem.pm[13]} = {16'hEE2A, 16'hF05C};
        {mem.pm[14], mem.pm[15], mem.pm[16]} =
            {16'h6610, 16'hC100, 16'hF200};
        t_reset();
        t_run();
        repeat (8) @(posedge sys_clk);
        t_phases();
        t_fetch();
        t_data();
        report_and_stop();
    end
endmodule : tb_top
